// ===== core/slmu_decode.sv
`include "slmu_defs.svh"
`default_nettype none

module slmu_decode (
   input  wire logic [31:0]      instr_i,
   output slmu_pkg::slmu_op_t    op_o,
   output logic      [4:0]       source_reg_field_o,
   output logic      [4:0]       dest_reg_field_o,
   output logic      [4:0]       shift_field_o,
   output logic                  record_flag_o
);

   logic [5:0] primary;
   logic [9:0] extended;

   // Field extraction shared by both forms
   assign primary            = instr_i[`SLMU_PO_MSB:`SLMU_PO_LSB];
   assign extended           = instr_i[`SLMU_XO_MSB:`SLMU_XO_LSB];
   assign source_reg_field_o = instr_i[`SLMU_SRC_MSB:`SLMU_SRC_LSB];
   assign dest_reg_field_o   = instr_i[`SLMU_DST_MSB:`SLMU_DST_LSB];
   assign shift_field_o      = instr_i[`SLMU_AMT_MSB:`SLMU_AMT_LSB];
   assign record_flag_o      = instr_i[`SLMU_REC_BIT];

   // Anything else is left to other units
   always_comb begin
      op_o = slmu_pkg::slmu_op_none;
      if (primary == `SLMU_PRIMARY_OP) begin
         if (extended == `SLMU_XO_IMM) begin
            op_o = slmu_pkg::slmu_op_imm;
         end else if (extended == `SLMU_XO_REG) begin
            op_o = slmu_pkg::slmu_op_reg;
         end
      end
   end

endmodule

`default_nettype wire

// ===== core/slmu_defs.svh
`ifndef SLMU_DEFS_SVH
`define SLMU_DEFS_SVH

// Instruction word, MSB-first bit 0 maps to vector bit 31
`define SLMU_PO_MSB        31
`define SLMU_PO_LSB        26
`define SLMU_SRC_MSB       25
`define SLMU_SRC_LSB       21
`define SLMU_DST_MSB       20
`define SLMU_DST_LSB       16
`define SLMU_AMT_MSB       15
`define SLMU_AMT_LSB       11
`define SLMU_XO_MSB        10
`define SLMU_XO_LSB        1
`define SLMU_REC_BIT       0

// Opcode values
`define SLMU_PRIMARY_OP    6'h1F
`define SLMU_XO_IMM        10'h2F8
`define SLMU_XO_REG        10'h2D8

// Shift-amount register: MSB-first bits 27-31 and bit 26
`define SLMU_N_MSB         4
`define SLMU_N_LSB         0
`define SLMU_ZFILL_BIT     5

// Word constants and reset values
`define SLMU_ALL_ONES      32'hFFFFFFFF
`define SLMU_ZERO_WORD     32'h00000000
`define SLMU_MQ_RST        32'h00000000
`define SLMU_REG_IDX_RST   5'h00
`define SLMU_N_RST         5'h00
`define SLMU_CR_RST        4'h0
`define SLMU_SIGN_BIT      31

// Condition field 0 layout
`define SLMU_CR_NEG        3
`define SLMU_CR_POS        2
`define SLMU_CR_ZERO       1
`define SLMU_CR_SO         0

`endif

// ===== core/slmu_pkg.sv
`default_nettype none

package slmu_pkg;

   // Which of the two forms an instruction word selects
   typedef enum logic [1:0] {
      slmu_op_none,
      slmu_op_imm,
      slmu_op_reg
   } slmu_op_t;

   // Sequencer states
   typedef enum logic [1:0] {
      slmu_st_idle,
      slmu_st_read,
      slmu_st_oper
   } slmu_state_t;

endpackage

`default_nettype wire

// ===== core/slmu_rotmask.sv
`include "slmu_defs.svh"
`default_nettype none

module slmu_rotmask (
   input  wire logic [31:0] src_i,
   input  wire logic [4:0]  n_i,
   input  wire logic        zero_fill_i,
   input  wire logic [31:0] mq_i,
   output logic      [31:0] rot_o,
   output logic      [31:0] merged_o
);

   logic [31:0] mask;
   logic [31:0] data;

   // N zeros in the most significant places, then ones
   function automatic logic [31:0] low_ones(input logic [4:0] n);
      low_ones = `SLMU_ALL_ONES >> n;
   endfunction

   // Left by 32-N equals right by N; 5-bit index wraps mod 32
   for (genvar i = 0; i < 32; i++) begin : g_rot
      assign rot_o[i] = src_i[5'(i) + n_i];
   end

   // Zero-fill picks the inverted mask and a zero data word
   always_comb begin
      if (zero_fill_i) begin
         mask = ~low_ones(n_i);
         data = `SLMU_ZERO_WORD;
      end else begin
         mask = low_ones(n_i);
         data = rot_o;
      end
   end

   // Mask one selects data, zero keeps the quotient register
   assign merged_o = (data & mask) | (mq_i & ~mask);

endmodule

`default_nettype wire

// ===== core/slmu_top.sv
// How it works
// - Opcode 31 with extended 760 is the immediate shift-right-long.
// - Opcode 31 with extended 728 is the register form.
// - Immediate form rotates source right by the 5-bit immediate N.
// - Immediate mask: N leading zeros, then ones.
// - Immediate form: rotated word to quotient reg, merge to dest.
// - Register form takes N from low five bits of amount reg.
// - Amount bit 26 clear: rotated word merged under N-zero mask.
// - Amount bit 26 set: zero word merged under N-ones mask.
// - Register form writes dest, leaves quotient register alone.
// - Record flag set updates condition field 0, else untouched.
// - Exception register is never written by either form.
`include "slmu_defs.svh"
`default_nettype none

// Reset is asynchronous and leaves every output low
module slmu_top (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        issue_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] rf_rdata_a_i,
   input  wire logic [31:0] rf_rdata_b_i,
   input  wire logic        summary_ovf_i,
   input  wire logic        mq_load_i,
   input  wire logic [31:0] mq_load_data_i,
   output logic             busy_o,
   output logic             rf_re_o,
   output logic      [4:0]  rf_raddr_a_o,
   output logic      [4:0]  rf_raddr_b_o,
   output logic             rf_we_o,
   output logic      [4:0]  rf_waddr_o,
   output logic      [31:0] rf_wdata_o,
   output logic             cr0_we_o,
   output logic      [3:0]  cr0_o,
   output logic      [31:0] mq_o,
   output logic             xer_we_o,
   output logic             done_o,
   output logic             unknown_o
);

   // Decoder outputs for the word on instr_i
   slmu_pkg::slmu_op_t     dec_op;
   logic [4:0]             dec_src;
   logic [4:0]             dec_dst;
   logic [4:0]             dec_amt;
   logic                   dec_rec;

   // Sequencer and captured instruction
   slmu_pkg::slmu_state_t  state_ff;
   slmu_pkg::slmu_state_t  nxt_state;
   slmu_pkg::slmu_op_t     op_ff;
   slmu_pkg::slmu_op_t     nxt_op;
   logic [4:0]             dst_ff;
   logic [4:0]             nxt_dst;
   logic [4:0]             sh_ff;
   logic [4:0]             nxt_sh;
   logic                   rec_ff;
   logic                   nxt_rec;

   // Read port toward the register file
   logic                   re_ff;
   logic                   nxt_re;
   logic [4:0]             raddr_a_ff;
   logic [4:0]             nxt_raddr_a;
   logic [4:0]             raddr_b_ff;
   logic [4:0]             nxt_raddr_b;
   logic                   busy_ff;
   logic                   nxt_busy;

   // Results
   logic                   we_ff;
   logic                   nxt_we;
   logic [4:0]             waddr_ff;
   logic [4:0]             nxt_waddr;
   logic [31:0]            wdata_ff;
   logic [31:0]            nxt_wdata;
   logic                   cr_we_ff;
   logic                   nxt_cr_we;
   logic [3:0]             cr_ff;
   logic [3:0]             nxt_cr;
   logic [31:0]            mq_ff;
   logic [31:0]            nxt_mq;
   logic                   xer_we_ff;
   logic                   done_ff;
   logic                   nxt_done;
   logic                   unknown_ff;
   logic                   nxt_unknown;

   // Datapath wiring
   // shift_n and zero_fill only carry meaning in cycle 2
   logic [4:0]             shift_n;
   logic                   zero_fill;
   logic [31:0]            rot_word;
   logic [31:0]            merged_word;

   // Decoder looks at the offered word every cycle; fields are cut
   // unconditionally and only dec_op says whether they mean anything
   slmu_decode u_decode (
      .instr_i            (instr_i),
      .op_o               (dec_op),
      .source_reg_field_o (dec_src),
      .dest_reg_field_o   (dec_dst),
      .shift_field_o      (dec_amt),
      .record_flag_o      (dec_rec)
   );

   // Amount source depends on the form captured at issue.
   // The amount register is only meaningful in cycle 2, when its
   // value stands; elsewhere shift_n may wander, which is harmless
   // because nothing registers the merge outside that cycle.
   always_comb begin
      if (op_ff == slmu_pkg::slmu_op_reg) begin
         shift_n   = rf_rdata_b_i[`SLMU_N_MSB:`SLMU_N_LSB];
         zero_fill = rf_rdata_b_i[`SLMU_ZFILL_BIT];
      end else begin
         shift_n   = sh_ff;
         zero_fill = 1'b0;
      end
   end

   // Rotator, mask generator and merge form one combinational path
   slmu_rotmask u_rotmask (
      .src_i       (rf_rdata_a_i),
      .n_i         (shift_n),
      .zero_fill_i (zero_fill),
      .mq_i        (mq_ff),
      .rot_o       (rot_word),
      .merged_o    (merged_word)
   );

   // Signed sign/zero test of a result word
   // Overflow summary is copied in, never computed: nothing here overflows
   function automatic logic [3:0] cr_of(input logic [31:0] w,
                                        input logic        so);
      logic neg;
      logic zero;
      neg   = w[`SLMU_SIGN_BIT];
      zero  = (w == `SLMU_ZERO_WORD);
      cr_of = '0;
      cr_of[`SLMU_CR_NEG]  = neg;
      cr_of[`SLMU_CR_POS]  = ~neg & ~zero;
      cr_of[`SLMU_CR_ZERO] = zero;
      cr_of[`SLMU_CR_SO]   = so;
   endfunction

   // Sequencer: issue, wait one cycle for read data, execute.
   // Both forms read two ports so latency is identical; the
   // immediate form simply ignores the second read value.
   //   cycle 0  word offered and accepted while idle
   //   cycle 1  read strobe and both addresses toward the file
   //   cycle 2  read data stand; rotate, mask and merge settle
   //   cycle 3  write, done and record strobes, back to idle
   // A new word may be accepted in cycle 3 already, so back-to-back
   // instructions run one every three cycles. Words offered while
   // busy are dropped silently; the unit upstream must hold them.
   // Foreign words never leave idle, so another unit may take them
   // in the very next cycle. Destination and record flag are kept
   // from issue, so a new word on instr_i cannot disturb them.
   always_comb begin
      nxt_state   = state_ff;
      nxt_op      = op_ff;
      nxt_dst     = dst_ff;
      nxt_sh      = sh_ff;
      nxt_rec     = rec_ff;
      nxt_re      = 1'b0;
      nxt_raddr_a = raddr_a_ff;
      nxt_raddr_b = raddr_b_ff;
      nxt_unknown = 1'b0;
      case (state_ff)
         slmu_pkg::slmu_st_idle: begin
            if (issue_i) begin
               if (dec_op != slmu_pkg::slmu_op_none) begin
                  nxt_state   = slmu_pkg::slmu_st_read;
                  nxt_op      = dec_op;
                  nxt_dst     = dec_dst;
                  nxt_sh      = dec_amt;
                  nxt_rec     = dec_rec;
                  nxt_re      = 1'b1;
                  nxt_raddr_a = dec_src;
                  nxt_raddr_b = dec_amt;
               end else begin
                  nxt_unknown = 1'b1;  // Not ours, flag it back
               end
            end
         end
         slmu_pkg::slmu_st_read: begin
            nxt_state = slmu_pkg::slmu_st_oper;
         end
         slmu_pkg::slmu_st_oper: begin
            nxt_state = slmu_pkg::slmu_st_idle;
         end
         default: begin
            nxt_state = slmu_pkg::slmu_st_idle;
         end
      endcase
      nxt_busy = (nxt_state != slmu_pkg::slmu_st_idle);
   end

   // Sequencer registers; reset puts everything at rest
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff   <= slmu_pkg::slmu_st_idle;
         op_ff      <= slmu_pkg::slmu_op_none;
         dst_ff     <= `SLMU_REG_IDX_RST;
         sh_ff      <= `SLMU_N_RST;
         rec_ff     <= 1'b0;
         re_ff      <= 1'b0;
         raddr_a_ff <= `SLMU_REG_IDX_RST;
         raddr_b_ff <= `SLMU_REG_IDX_RST;
         busy_ff    <= 1'b0;
         unknown_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         op_ff      <= nxt_op;
         dst_ff     <= nxt_dst;
         sh_ff      <= nxt_sh;
         rec_ff     <= nxt_rec;
         re_ff      <= nxt_re;
         raddr_a_ff <= nxt_raddr_a;
         raddr_b_ff <= nxt_raddr_b;
         busy_ff    <= nxt_busy;
         unknown_ff <= nxt_unknown;
      end
   end

   // Result stage: one-cycle write pulses after execution.
   // An instruction's own quotient update beats an outside load
   // in the same cycle, since it is the later architectural write.
   // Address and data hold after the strobe drops, so a slow file
   // may still look at them; condition bits likewise hold until
   // the next recording instruction. done_o rises with the write
   // strobe, so the caller needs to watch only one of them.
   // The merge reads the quotient register as it stood in cycle 2.
   always_comb begin
      nxt_we    = 1'b0;
      nxt_waddr = waddr_ff;
      nxt_wdata = wdata_ff;
      nxt_cr_we = 1'b0;
      nxt_cr    = cr_ff;
      nxt_done  = 1'b0;
      nxt_mq    = mq_ff;
      if (mq_load_i) begin
         nxt_mq = mq_load_data_i;
      end
      if (state_ff == slmu_pkg::slmu_st_oper) begin
         nxt_we    = 1'b1;
         nxt_waddr = dst_ff;
         nxt_wdata = merged_word;
         nxt_done  = 1'b1;
         if (op_ff == slmu_pkg::slmu_op_imm) begin
            nxt_mq = rot_word;
         end
         if (rec_ff) begin
            nxt_cr_we = 1'b1;
            nxt_cr    = cr_of(merged_word, summary_ovf_i);
         end
      end
   end

   // Result registers
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         we_ff     <= 1'b0;
         waddr_ff  <= `SLMU_REG_IDX_RST;
         wdata_ff  <= `SLMU_ZERO_WORD;
         cr_we_ff  <= 1'b0;
         cr_ff     <= `SLMU_CR_RST;
         done_ff   <= 1'b0;
         mq_ff     <= `SLMU_MQ_RST;
         xer_we_ff <= 1'b0;
      end else begin
         we_ff     <= nxt_we;
         waddr_ff  <= nxt_waddr;
         wdata_ff  <= nxt_wdata;
         cr_we_ff  <= nxt_cr_we;
         cr_ff     <= nxt_cr;
         done_ff   <= nxt_done;
         mq_ff     <= nxt_mq;
         xer_we_ff <= 1'b0;  // Exception register never written
      end
   end

   // Every output straight from a flip-flop
   // so the register file and condition logic see glitch-free strobes
   assign busy_o       = busy_ff;
   assign rf_re_o      = re_ff;
   assign rf_raddr_a_o = raddr_a_ff;
   assign rf_raddr_b_o = raddr_b_ff;
   assign rf_we_o      = we_ff;
   assign rf_waddr_o   = waddr_ff;
   assign rf_wdata_o   = wdata_ff;
   assign cr0_we_o     = cr_we_ff;
   assign cr0_o        = cr_ff;
   assign mq_o         = mq_ff;
   assign xer_we_o     = xer_we_ff;
   assign done_o       = done_ff;
   assign unknown_o    = unknown_ff;

endmodule

`default_nettype wire

// ===== verif/shift_right_long_merge_unit_tb.sv
`default_nettype none

module shift_right_long_merge_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys_i, rst_i, issue_i, summary_ovf_i, mq_load_i;
   logic [31:0] instr_i, mq_load_data_i, rf_rdata_a_i, rf_rdata_b_i;
   logic        busy_o, rf_re_o, rf_we_o, cr0_we_o, xer_we_o, done_o;
   logic        unknown_o;
   logic [4:0]  rf_raddr_a_o, rf_raddr_b_o, rf_waddr_o;
   logic [31:0] rf_wdata_o, mq_o;
   logic [3:0]  cr0_o, last_cr;
   int          fails, cmp_count;

   slmu_top slmu_top_i (.clk_sys_i, .rst_i, .issue_i, .instr_i,
      .rf_rdata_a_i, .rf_rdata_b_i, .summary_ovf_i, .mq_load_i,
      .mq_load_data_i, .busy_o, .rf_re_o, .rf_raddr_a_o, .rf_raddr_b_o,
      .rf_we_o, .rf_waddr_o, .rf_wdata_o, .cr0_we_o, .cr0_o, .mq_o,
      .xer_we_o, .done_o, .unknown_o);

   slmu_rf_model slmu_rf_model_i (.clk_i(clk_sys_i), .re_i(rf_re_o),
      .addr_a_i(rf_raddr_a_o), .addr_b_i(rf_raddr_b_o),
      .data_a_o(rf_rdata_a_i), .data_b_o(rf_rdata_b_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask

   task automatic end_sim;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Source in r4, amount in r8, result to r6
   function automatic logic [31:0] mk(input logic [9:0] xo,
                                      input logic [4:0] f, input logic rec);
      return {6'h1F, 5'h04, 5'h06, f, xo, rec};
   endfunction

   // Preload quotient reg, issue one word, judge the write-back
   task automatic exec(input logic [31:0] ins, a, b, mq0, input logic so,
                       input logic [31:0] er, em, input logic [3:0] ec);
      int k;
      @(posedge clk_sys_i);
      mq_load_i <= 1'b1;
      mq_load_data_i <= mq0;
      slmu_rf_model_i.regs[4] = a;
      slmu_rf_model_i.regs[8] = b;
      @(posedge clk_sys_i);
      mq_load_i <= 1'b0;
      issue_i <= 1'b1;
      instr_i <= ins;
      summary_ovf_i <= so;
      @(posedge clk_sys_i);
      issue_i <= 1'b0;
      for (k = 0; k < 6 && done_o !== 1'b1; k++) begin
         @(posedge clk_sys_i);
         #1;
      end
      if (ins[0])
         last_cr = ec;
      chk(done_o === 1'b1 && rf_we_o === 1'b1, "no write");
      chk(rf_wdata_o === er && rf_waddr_o === 5'h06, "dest word");
      chk(mq_o === em, "quotient reg");
      chk(xer_we_o === 1'b0, "exception strobe");
      chk(cr0_we_o === ins[0] && cr0_o === last_cr, "cond field");
   endtask

   task automatic t_imm;
      exec(mk(10'h2F8, 5'h04, 1'b0), 32'h9000300F, 32'hFFFFFFFF, 32'h11111111,
           1'b0, 32'h19000300, 32'hF9000300, 4'h0);
      exec(mk(10'h2F8, 5'h04, 1'b1), 32'hB0043000, 32'h0, 32'hFFFFFFFF,
           1'b0, 32'hFB004300, 32'h0B004300, 4'h8);
   endtask

   task automatic t_reg;
      exec(mk(10'h2D8, 5'h08, 1'b0), 32'h9000300F, 32'h24, 32'hFFFFFFFF,
           1'b0, 32'h0FFFFFFF, 32'hFFFFFFFF, 4'h0);
      exec(mk(10'h2D8, 5'h08, 1'b1), 32'hB0043000, 32'h4, 32'hFFFFFFFF,
           1'b0, 32'hFB004300, 32'hFFFFFFFF, 4'h8);
   endtask

   // Shift counts 0 and 31, zero result, set overflow summary
   task automatic t_bounds;
      exec(mk(10'h2F8, 5'h00, 1'b1), 32'h80000001, 32'h0, 32'h12345678,
           1'b1, 32'h80000001, 32'h80000001, 4'h9);
      exec(mk(10'h2F8, 5'h1F, 1'b1), 32'h2, 32'h0, 32'hFFFFFFFF,
           1'b0, 32'hFFFFFFFE, 32'h4, 4'h8);
      exec(mk(10'h2D8, 5'h08, 1'b1), 32'hDEADBEEF, 32'h20, 32'h0,
           1'b0, 32'h0, 32'h0, 4'h2);
      exec(mk(10'h2D8, 5'h08, 1'b1), 32'h2, 32'hFFFFFFDF, 32'h7FFFFFFF,
           1'b1, 32'h7FFFFFFE, 32'h7FFFFFFF, 4'h5);
   endtask

   // Neighbouring encodings must be turned away without a read
   task automatic t_unknown;
      logic [31:0] w [3];
      w = '{mk(10'h2D9, 5'h08, 1'b0), mk(10'h2B8, 5'h04, 1'b0),
            mk(10'h2F8, 5'h04, 1'b0) ^ 32'h04000000};
      foreach (w[i]) begin
         @(posedge clk_sys_i);
         issue_i <= 1'b1;
         instr_i <= w[i];
         @(posedge clk_sys_i);
         issue_i <= 1'b0;
         #1;
         chk(unknown_o === 1'b1 && !rf_re_o, "foreign word");
      end
   endtask

   // A word offered while busy is ignored; a same-edge outside load
   // of the quotient register loses to the instruction's own update
   task automatic t_busy;
      slmu_rf_model_i.regs[4] = 32'h9000300F;
      @(posedge clk_sys_i);
      mq_load_i <= 1'b1;
      mq_load_data_i <= 32'h11111111;
      issue_i <= 1'b1;
      instr_i <= mk(10'h2F8, 5'h04, 1'b0);
      @(posedge clk_sys_i);
      mq_load_i <= 1'b0;
      #1;
      chk(rf_re_o === 1'b1 && busy_o === 1'b1, "not taken");
      @(posedge clk_sys_i);
      mq_load_i <= 1'b1;
      mq_load_data_i <= 32'h55555555;
      #1;
      chk(rf_re_o === 1'b0 && busy_o === 1'b1, "busy taken");
      @(posedge clk_sys_i);
      mq_load_i <= 1'b0;
      issue_i <= 1'b0;
      #1;
      chk(rf_we_o === 1'b1 && done_o === 1'b1, "no write");
      chk(rf_wdata_o === 32'h19000300, "held word");
      chk(mq_o === 32'hF9000300 && !cr0_we_o, "update lost");
      @(posedge clk_sys_i);
      #1;
      chk(!rf_re_o && !busy_o && !rf_we_o, "busy word kept");
      chk(mq_o === 32'hF9000300, "quotient moved");
   endtask

   initial begin
      {rst_i, issue_i, summary_ovf_i, mq_load_i} = 4'h8;
      instr_i = 32'h0;
      mq_load_data_i = 32'h0;
      {fails, cmp_count} = '0;
      last_cr = 4'h0;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_imm;
      t_reg;
      t_bounds;
      t_unknown;
      t_busy;
      end_sim;
   end

   // Whole run is well under a hundred cycles
   initial begin
      repeat (2000) @(posedge clk_sys_i);
      fails++;
      end_sim;
   end
endmodule

`default_nettype wire

// ===== verif/slmu_rf_model.sv
`default_nettype none

module slmu_rf_model (
   input  wire logic        clk_i,
   input  wire logic        re_i,
   input  wire logic [4:0]  addr_a_i,
   input  wire logic [4:0]  addr_b_i,
   output logic      [31:0] data_a_o,
   output logic      [31:0] data_b_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [31:0] regs [32];

   initial begin
      data_a_o = 32'h0;
      data_b_o = 32'h0;
   end

   // Read data stand only in the cycle after a read; otherwise they flip,
   // so a block that samples late cannot pass by luck
   always @(posedge clk_i) begin
      data_a_o <= re_i ? regs[addr_a_i] : ~data_a_o;
      data_b_o <= re_i ? regs[addr_b_i] : ~data_b_o;
   end
endmodule

`default_nettype wire

// ===== verif/slmu_top_assertions.sv
`default_nettype none

module slmu_top_assertions (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        issue_i,
   input wire logic [31:0] instr_i,
   input wire logic [31:0] rf_rdata_a_i,
   input wire logic [31:0] rf_rdata_b_i,
   input wire logic        summary_ovf_i,
   input wire logic        mq_load_i,
   input wire logic        busy_o,
   input wire logic        rf_re_o,
   input wire logic [4:0]  rf_raddr_a_o,
   input wire logic [4:0]  rf_raddr_b_o,
   input wire logic        rf_we_o,
   input wire logic [4:0]  rf_waddr_o,
   input wire logic [31:0] rf_wdata_o,
   input wire logic        cr0_we_o,
   input wire logic [3:0]  cr0_o,
   input wire logic [31:0] mq_o,
   input wire logic        xer_we_o,
   input wire logic        done_o,
   input wire logic        unknown_o
);
   logic [31:0] ins_ff, src_ff, amt_ff, mq_ff, nxt_ins, nxt_src, nxt_amt;
   logic [31:0] nxt_mq, rot, mask, exp;
   logic        so_ff, re_d_ff, nxt_so, known, is_reg, zf;
   logic [4:0]  n;

   // Shadow of the operands as the block should have seen them
   always_comb begin
      known = instr_i[31:26] == 6'h1F
              && (instr_i[10:1] == 10'h2F8 || instr_i[10:1] == 10'h2D8);
      nxt_ins = (issue_i && !busy_o) ? instr_i : ins_ff;
      nxt_src = re_d_ff ? rf_rdata_a_i : src_ff;
      nxt_amt = re_d_ff ? rf_rdata_b_i : amt_ff;
      nxt_mq = re_d_ff ? mq_o : mq_ff;
      nxt_so = re_d_ff ? summary_ovf_i : so_ff;
      is_reg = ins_ff[10:1] == 10'h2D8;
      n = is_reg ? amt_ff[4:0] : ins_ff[15:11];
      zf = is_reg && amt_ff[5];
      rot = (src_ff >> n) | (src_ff << (6'd32 - {1'b0, n}));
      mask = zf ? ~(32'hFFFFFFFF >> n) : (32'hFFFFFFFF >> n);
      exp = ((zf ? 32'h0 : rot) & mask) | (mq_ff & ~mask);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {ins_ff, src_ff, amt_ff, mq_ff} <= '0;
         {so_ff, re_d_ff} <= '0;
      end else begin
         {ins_ff, src_ff, amt_ff, mq_ff} <=
            {nxt_ins, nxt_src, nxt_amt, nxt_mq};
         {so_ff, re_d_ff} <= {nxt_so, rf_re_o};
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   AST_XER_NEVER: assert property (!xer_we_o)
      else $error("exception register strobe raised");
   AST_ISSUE_READ: assert property (
      issue_i && !busy_o && known |=> rf_re_o && busy_o
      && rf_raddr_a_o == $past(instr_i[25:21])
      && rf_raddr_b_o == $past(instr_i[15:11]))
      else $error("known word not read");
   AST_UNKNOWN: assert property (
      issue_i && !busy_o && !known |=> unknown_o && !rf_re_o && !busy_o)
      else $error("foreign word not flagged");
   AST_LATENCY: assert property (
      rf_re_o |=> busy_o && !rf_we_o ##1 rf_we_o && done_o && !busy_o)
      else $error("write not two cycles after read");
   AST_RESULT: assert property (
      rf_we_o |-> rf_wdata_o == exp && rf_waddr_o == ins_ff[20:16])
      else $error("destination value wrong");
   AST_MQ_IMM: assert property (
      rf_we_o && !is_reg |-> mq_o == rot)
      else $error("quotient reg not rotated word");
   AST_MQ_REG: assert property (
      rf_we_o && is_reg && !$past(mq_load_i) |-> mq_o == $past(mq_o))
      else $error("quotient reg altered");
   AST_CR_SET: assert property (
      rf_we_o && ins_ff[0] |-> cr0_we_o
      && cr0_o == {exp[31], !exp[31] && exp != 0, exp == 0, so_ff})
      else $error("condition field wrong");
   AST_CR_KEEP: assert property (
      rf_we_o && !ins_ff[0] |-> !cr0_we_o && $stable(cr0_o))
      else $error("condition field touched");
endmodule

bind slmu_top slmu_top_assertions slmu_top_assertions_i (.clk_sys_i,
   .rst_i, .issue_i, .instr_i, .rf_rdata_a_i, .rf_rdata_b_i, .summary_ovf_i,
   .mq_load_i, .busy_o, .rf_re_o, .rf_raddr_a_o, .rf_raddr_b_o, .rf_we_o,
   .rf_waddr_o, .rf_wdata_o, .cr0_we_o, .cr0_o, .mq_o, .xer_we_o, .done_o,
   .unknown_o);

`default_nettype wire
